// *** csp_pkg.sv ***
package csp_pkg;

	// =========================================================================
	// Frame layout
	// =========================================================================
	localparam int unsigned FRAME_W = 32;
	localparam int unsigned ADDR_W  = 4;
	localparam int unsigned DATA_W  = 28;
	localparam int unsigned ADDR_LSB = 0;
	localparam int unsigned DATA_LSB = 4;
	localparam int unsigned CNT_W   = 6;
	localparam logic [CNT_W-1:0] FRAME_BITS = 6'h20;

	// =========================================================================
	// Command codes
	// =========================================================================
	localparam logic [ADDR_W-1:0] CODE_WR_REG0 = 4'h0;
	localparam logic [ADDR_W-1:0] CODE_WR_REG1 = 4'h1;
	localparam logic [ADDR_W-1:0] CODE_WR_REG2 = 4'h2;
	localparam logic [ADDR_W-1:0] CODE_READ    = 4'hE;
	localparam logic [ADDR_W-1:0] CODE_COPY    = 4'hF;
	localparam logic [DATA_W-1:0] COPY_UNLOCK  = 28'h000_0001;
	localparam logic [FRAME_W-1:0] COPY_WORD   = 32'h0000_001F;

	// =========================================================================
	// Reset values
	// =========================================================================
	localparam logic [DATA_W-1:0] REG2_RESET = 28'h000_0000;
	localparam logic [DATA_W-1:0] NVM_INIT   = 28'h000_0000;

	// =========================================================================
	// Timing
	// =========================================================================
	localparam int unsigned CLK_KHZ         = 125000;
	localparam int unsigned SETTLE_PERIODS  = 16384;
	localparam int unsigned VCO_CAL_PERIODS = 550;
	localparam int unsigned NVM_WAIT_MS     = 50;
	localparam int unsigned NVM_WAIT_CYCLES = NVM_WAIT_MS * CLK_KHZ;
	localparam int unsigned HALF_DIV        = 4;
	localparam int unsigned GAP_CYCLES      = 4;

endpackage

// *** csp_spi_dev.sv ***
`timescale 1ns/1ps
module csp_spi_dev #(
	parameter int unsigned          SETTLE_CYCLES = csp_pkg::SETTLE_PERIODS,
	parameter logic [csp_pkg::DATA_W-1:0] NVM0_INIT = csp_pkg::NVM_INIT,
	parameter logic [csp_pkg::DATA_W-1:0] NVM1_INIT = csp_pkg::NVM_INIT
) (
	// Clock and reset
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_i,
	// Serial link
	csp_spi_if.dev                          spi,
	// Device core
	input  wire logic                       pd_n_i,
	input  wire logic                       phase_compare_clock_i,
	output logic [csp_pkg::DATA_W-1:0]      cfg_reg0_o,
	output logic [csp_pkg::DATA_W-1:0]      cfg_reg1_o,
	output logic [csp_pkg::DATA_W-1:0]      cfg_reg2_o,
	output logic                            vco_tuning_o,
	output logic                            ready_o,
	output logic                            nvm_write_o
);

	localparam int unsigned SET_W = $clog2(SETTLE_CYCLES + 1);
	localparam int unsigned CAL_W = $clog2(csp_pkg::VCO_CAL_PERIODS + 1);
	localparam logic [SET_W-1:0] SETTLE_LAST = SET_W'(SETTLE_CYCLES - 1);
	localparam logic [CAL_W-1:0] CAL_LAST    = CAL_W'(csp_pkg::VCO_CAL_PERIODS - 1);

	typedef enum logic [3:0] {
		ST_LOAD   = 4'b0001,
		ST_SETTLE = 4'b0010,
		ST_CAL    = 4'b0100,
		ST_READY  = 4'b1000
	} csp_start_e;

	// =========================================================================
	// Link edge detection
	// =========================================================================
	logic sclk_q;
	logic le_q;
	logic pc_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q <= 1'b0;
			le_q   <= 1'b1;
			pc_q   <= 1'b0;
		end else begin
			sclk_q <= spi.sclk;
			le_q   <= spi.frame_latch_enable;
			pc_q   <= phase_compare_clock_i;
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic le_fall;
	logic le_rise;
	logic pc_rise;

	assign sclk_rise = spi.sclk & ~sclk_q;
	assign sclk_fall = ~spi.sclk & sclk_q;
	assign le_fall   = ~spi.frame_latch_enable & le_q;
	assign le_rise   = spi.frame_latch_enable & ~le_q;
	assign pc_rise   = phase_compare_clock_i & ~pc_q;

	// =========================================================================
	// Start-up sequencing
	// =========================================================================
	csp_start_e       state_q;
	logic [SET_W-1:0] settle_q;
	logic [CAL_W-1:0] cal_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q  <= ST_LOAD;
			settle_q <= '0;
			cal_q    <= '0;
		end else if (!pd_n_i) begin
			state_q  <= ST_LOAD;
		end else begin
			unique case (state_q)
				ST_LOAD: begin
					settle_q <= '0;
					state_q  <= ST_SETTLE;
				end
				ST_SETTLE: begin
					settle_q <= settle_q + 1'b1;
					if (settle_q == SETTLE_LAST) begin
						cal_q   <= '0;
						state_q <= ST_CAL;
					end
				end
				ST_CAL: begin
					if (pc_rise) begin
						cal_q <= cal_q + 1'b1;
						if (cal_q == CAL_LAST) begin
							state_q <= ST_READY;
						end
					end
				end
				ST_READY: begin
					state_q <= ST_READY;
				end
			endcase
		end
	end

	assign vco_tuning_o = state_q[2];
	assign ready_o      = state_q[3];

	// =========================================================================
	// Frame receiver
	// =========================================================================
	logic [csp_pkg::FRAME_W-1:0] in_q;
	logic [csp_pkg::CNT_W-1:0]   cnt_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			in_q  <= '0;
			cnt_q <= '0;
		end else if (le_fall) begin
			cnt_q <= '0;
		end else if (!spi.frame_latch_enable && sclk_rise
				&& cnt_q != csp_pkg::FRAME_BITS) begin
			// First bit lands at the top and walks down to bit 0.
			in_q  <= {spi.mosi, in_q[csp_pkg::FRAME_W-1:1]};
			cnt_q <= cnt_q + 1'b1;
		end
	end

	logic [csp_pkg::ADDR_W-1:0] cmd_code;
	logic [csp_pkg::DATA_W-1:0] cmd_data;
	logic                       cmd_go;

	assign cmd_code = in_q[csp_pkg::ADDR_LSB +: csp_pkg::ADDR_W];
	assign cmd_data = in_q[csp_pkg::DATA_LSB +: csp_pkg::DATA_W];
	// Short frames and frames during the load step are dropped.
	assign cmd_go   = le_rise && cnt_q == csp_pkg::FRAME_BITS
			&& state_q != ST_LOAD;

	// =========================================================================
	// Working registers and stored configuration
	// =========================================================================
	logic [csp_pkg::DATA_W-1:0] reg_q [3];
	logic [csp_pkg::DATA_W-1:0] nvm_q [2];
	logic                       nvm_wr_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_q[0] <= csp_pkg::NVM_INIT;
			reg_q[1] <= csp_pkg::NVM_INIT;
			reg_q[2] <= csp_pkg::REG2_RESET;
		end else if (state_q == ST_LOAD) begin
			reg_q[0] <= nvm_q[0];
			reg_q[1] <= nvm_q[1];
			reg_q[2] <= csp_pkg::REG2_RESET;
		end else if (cmd_go) begin
			unique case (cmd_code)
				csp_pkg::CODE_WR_REG0: reg_q[0] <= cmd_data;
				csp_pkg::CODE_WR_REG1: reg_q[1] <= cmd_data;
				csp_pkg::CODE_WR_REG2: reg_q[2] <= cmd_data;
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			nvm_q[0] <= NVM0_INIT;
			nvm_q[1] <= NVM1_INIT;
			nvm_wr_q <= 1'b0;
		end else begin
			nvm_wr_q <= 1'b0;
			if (cmd_go && cmd_code == csp_pkg::CODE_COPY
					&& cmd_data == csp_pkg::COPY_UNLOCK) begin
				nvm_q[0] <= reg_q[0];
				nvm_q[1] <= reg_q[1];
				nvm_wr_q <= 1'b1;
			end
		end
	end

	assign cfg_reg0_o  = reg_q[0];
	assign cfg_reg1_o  = reg_q[1];
	assign cfg_reg2_o  = reg_q[2];
	assign nvm_write_o = nvm_wr_q;

	// =========================================================================
	// Read-back
	// =========================================================================
	logic                       rd_pend_q;
	logic [csp_pkg::ADDR_W-1:0] rd_addr_q;
	logic [csp_pkg::FRAME_W-1:0] out_q;
	logic                       out_act_q;
	logic                       oe_q;
	logic [csp_pkg::FRAME_W-1:0] rd_word;

	always_comb begin
		rd_word = '0;
		unique case (rd_addr_q)
			csp_pkg::CODE_WR_REG0: rd_word = {reg_q[0], rd_addr_q};
			csp_pkg::CODE_WR_REG1: rd_word = {reg_q[1], rd_addr_q};
			csp_pkg::CODE_WR_REG2: rd_word = {reg_q[2], rd_addr_q};
			default:               rd_word = '0;
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= '0;
		end else if (cmd_go) begin
			rd_pend_q <= cmd_code == csp_pkg::CODE_READ;
			rd_addr_q <= cmd_data[csp_pkg::ADDR_W-1:0];
		end else if (le_fall) begin
			rd_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			out_q     <= '0;
			out_act_q <= 1'b0;
		end else if (le_fall) begin
			out_q     <= rd_word;
			out_act_q <= rd_pend_q;
		end else if (spi.frame_latch_enable) begin
			out_act_q <= 1'b0;
		end else if (sclk_fall) begin
			out_q     <= {1'b0, out_q[csp_pkg::FRAME_W-1:1]};
		end
	end

	// Open drain: only a zero is driven; a one leaves the pull-up in charge.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			oe_q <= 1'b0;
		end else begin
			oe_q <= out_act_q & ~out_q[0] & ~spi.frame_latch_enable;
		end
	end

	assign spi.miso_drv = 1'b0;
	assign spi.miso_oe  = oe_q;

endmodule

// *** csp_spi_host.sv ***
`timescale 1ns/1ps
module csp_spi_host #(
	parameter int unsigned HALF_DIV        = csp_pkg::HALF_DIV,
	parameter int unsigned GAP_CYCLES      = csp_pkg::GAP_CYCLES,
	parameter int unsigned NVM_WAIT_CYCLES = csp_pkg::NVM_WAIT_CYCLES
) (
	// Clock and reset
	input  wire logic                        ref_clk_i,
	input  wire logic                        rst_i,
	// Serial link
	csp_spi_if.host                          spi,
	// User side
	input  wire logic                        start_i,
	input  wire logic [csp_pkg::FRAME_W-1:0] word_i,
	output logic                             busy_o,
	output logic                             done_o,
	output logic [csp_pkg::FRAME_W-1:0]      rdata_o
);

	localparam int unsigned CW = $clog2(NVM_WAIT_CYCLES + HALF_DIV + GAP_CYCLES + 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(HALF_DIV - 1);
	localparam logic [CW-1:0] GAP_LAST  = CW'(GAP_CYCLES - 1);
	localparam logic [CW-1:0] WAIT_LAST = CW'(NVM_WAIT_CYCLES - 1);

	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_LOW  = 5'b00010,
		H_HIGH = 5'b00100,
		H_GAP  = 5'b01000,
		H_WAIT = 5'b10000
	} csp_host_e;

	// =========================================================================
	// Frame sequencer
	// =========================================================================
	csp_host_e                   state_q;
	logic [CW-1:0]               cnt_q;
	logic [csp_pkg::CNT_W-1:0]   bit_q;
	logic [csp_pkg::FRAME_W-1:0] tx_q;
	logic [csp_pkg::FRAME_W-1:0] rx_q;
	logic                        sclk_q;
	logic                        mosi_q;
	logic                        le_q;
	logic                        copy_q;
	logic                        busy_q;
	logic                        done_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= H_IDLE;
			cnt_q   <= '0;
			bit_q   <= '0;
			tx_q    <= '0;
			rx_q    <= '0;
			sclk_q  <= 1'b0;
			mosi_q  <= 1'b0;
			le_q    <= 1'b1;
			copy_q  <= 1'b0;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
			rdata_o <= '0;
		end else begin
			done_q <= 1'b0;
			cnt_q  <= cnt_q + 1'b1;
			unique case (state_q)
				H_IDLE: begin
					cnt_q <= '0;
					if (start_i) begin
						tx_q    <= word_i;
						mosi_q  <= word_i[0];
						le_q    <= 1'b0;
						bit_q   <= '0;
						copy_q  <= word_i == csp_pkg::COPY_WORD;
						busy_q  <= 1'b1;
						state_q <= H_LOW;
					end
				end
				H_LOW: begin
					if (cnt_q == HALF_LAST) begin
						cnt_q <= '0;
						if (bit_q == csp_pkg::FRAME_BITS) begin
							le_q    <= 1'b1;
							rdata_o <= rx_q;
							done_q  <= 1'b1;
							state_q <= H_GAP;
						end else begin
							sclk_q  <= 1'b1;
							rx_q    <= {spi.miso, rx_q[csp_pkg::FRAME_W-1:1]};
							state_q <= H_HIGH;
						end
					end
				end
				H_HIGH: begin
					if (cnt_q == HALF_LAST) begin
						cnt_q   <= '0;
						sclk_q  <= 1'b0;
						tx_q    <= {1'b0, tx_q[csp_pkg::FRAME_W-1:1]};
						mosi_q  <= tx_q[1];
						bit_q   <= bit_q + 1'b1;
						state_q <= H_LOW;
					end
				end
				H_GAP: begin
					// Latch stays high between frames: no streaming.
					if (cnt_q == GAP_LAST) begin
						cnt_q <= '0;
						if (copy_q) begin
							state_q <= H_WAIT;
						end else begin
							busy_q  <= 1'b0;
							state_q <= H_IDLE;
						end
					end
				end
				H_WAIT: begin
					if (cnt_q == WAIT_LAST) begin
						busy_q  <= 1'b0;
						state_q <= H_IDLE;
					end
				end
			endcase
		end
	end

	assign spi.sclk               = sclk_q;
	assign spi.mosi               = mosi_q;
	assign spi.frame_latch_enable = le_q;
	assign busy_o                 = busy_q;
	assign done_o                 = done_q;

endmodule

// *** csp_spi_if.sv ***
`timescale 1ns/1ps
// Serial link between host and device; the open-drain line idles high.
interface csp_spi_if;
	logic sclk;
	logic mosi;
	logic frame_latch_enable;
	logic miso_drv;
	logic miso_oe;
	logic miso;

	// Pull-up: the line is low only while the device drives it low.
	assign miso = miso_oe ? miso_drv : 1'b1;

	modport dev (
		input  sclk,
		input  mosi,
		input  frame_latch_enable,
		output miso_drv,
		output miso_oe
	);

	modport host (
		output sclk,
		output mosi,
		output frame_latch_enable,
		input  miso
	);
endinterface

// *** csp_spi_sva.sv ***
`timescale 1ns/1ps
module csp_spi_sva (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// Serial link
	input wire logic sclk,
	input wire logic mosi,
	input wire logic frame_latch_enable,
	input wire logic miso_drv,
	input wire logic miso_oe
);
	// =========================================================================
	// Bit counter of the current frame
	// =========================================================================
	logic       sclk_q;
	logic [5:0] bits_q;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bits_q <= 6'h00;
		end else if (frame_latch_enable) begin
			bits_q <= 6'h00;
		end else if (sclk && !sclk_q) begin
			bits_q <= bits_q + 6'h01;
		end
	end

	// =========================================================================
	// Link checks
	// =========================================================================
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_drv_low;
		miso_drv == 1'b0;
	endproperty
	a_drv_low: assert property (p_drv_low) else $error("miso drive value not low");

	property p_oe_idle;
		frame_latch_enable [*4] |-> !miso_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("miso held outside frame");

	property p_oe_window;
		miso_oe |-> !$past(frame_latch_enable, 2);
	endproperty
	a_oe_window: assert property (p_oe_window) else $error("miso driven outside frame");

	property p_clk_win;
		$changed(sclk) |-> !frame_latch_enable;
	endproperty
	a_clk_win: assert property (p_clk_win) else $error("sclk moved with latch high");

	property p_mosi_fall;
		$changed(mosi) |-> !sclk;
	endproperty
	a_mosi_fall: assert property (p_mosi_fall) else $error("mosi changed with sclk high");

	property p_rise_hold;
		$rose(sclk) |-> sclk [*4] ##1 !sclk;
	endproperty
	a_rise_hold: assert property (p_rise_hold) else $error("sclk high phase wrong");

	property p_low_hold;
		$fell(sclk) |-> !sclk [*4];
	endproperty
	a_low_hold: assert property (p_low_hold) else $error("sclk low phase short");

	property p_first_rise;
		$fell(frame_latch_enable) |-> !sclk [*4] ##1 sclk;
	endproperty
	a_first_rise: assert property (p_first_rise) else $error("first sclk rise late");

	property p_gap;
		$rose(frame_latch_enable) |-> frame_latch_enable [*4];
	endproperty
	a_gap: assert property (p_gap) else $error("frames back to back");

	property p_count;
		$rose(frame_latch_enable) |-> bits_q == 6'h20;
	endproperty
	a_count: assert property (p_count) else $error("frame not 32 bits");
endmodule

// *** test_clock_synth_spi_config_port.sv ***
`timescale 1ns/1ps
module test_clock_synth_spi_config_port;
	// =========================================================================
	// Signals
	// =========================================================================
	logic        ref_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic        start_i   = 1'b0;
	logic        pd_n_i    = 1'b1;
	logic [31:0] word_i    = 32'h0000_0000;
	logic [1:0]  div_q     = 2'h0;
	logic        pcc;
	logic        busy_o;
	logic        done_o;
	logic [31:0] rdata_o;
	logic [31:0] seen;
	logic        vco_tuning_o;
	logic        ready_o;
	logic        nvm_write_o;
	logic [27:0] cfg_reg0_o;
	logic [27:0] cfg_reg1_o;
	logic [27:0] cfg_reg2_o;
	logic [27:0] cfg [3];
	logic [27:0] dat [3] = '{28'h123_4567, 28'h89A_BCDE, 28'h0F0_F0F0};
	int          n_fail = 0;
	int          checks_done = 0;
	int          n_nvm = 0;
	int          n_busy = 0;

	assign cfg[0] = cfg_reg0_o;
	assign cfg[1] = cfg_reg1_o;
	assign cfg[2] = cfg_reg2_o;
	assign pcc = div_q[1];

	csp_spi_if spi ();
	csp_spi_dev #(.SETTLE_CYCLES(16)) i_csp_spi_dev (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.spi(spi), .pd_n_i(pd_n_i), .phase_compare_clock_i(pcc), .cfg_reg0_o(cfg_reg0_o),
		.cfg_reg1_o(cfg_reg1_o), .cfg_reg2_o(cfg_reg2_o), .vco_tuning_o(vco_tuning_o),
		.ready_o(ready_o), .nvm_write_o(nvm_write_o));
	csp_spi_host #(.NVM_WAIT_CYCLES(20)) i_csp_spi_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.spi(spi), .start_i(start_i), .word_i(word_i), .busy_o(busy_o), .done_o(done_o),
		.rdata_o(rdata_o));
	csp_spi_sva i_csp_spi_sva (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk(spi.sclk),
		.mosi(spi.mosi), .frame_latch_enable(spi.frame_latch_enable),
		.miso_drv(spi.miso_drv), .miso_oe(spi.miso_oe));

	initial forever #4 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) div_q <= div_q + 2'h1;
	always @(posedge ref_clk_i) if (nvm_write_o === 1'b1) n_nvm++;
	always @(posedge ref_clk_i) if (busy_o === 1'b1) n_busy++;

	// =========================================================================
	// Shared tasks
	// =========================================================================
	task automatic give_verdict;
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("Error %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask

	task automatic send(input logic [31:0] w);
		int k;
		k = 0;
		@(posedge ref_clk_i);
		start_i <= 1'b1;
		word_i  <= w;
		@(posedge ref_clk_i);
		start_i <= 1'b0;
		while (done_o !== 1'b1 && k < 400) begin
			wait_cyc(1);
			k++;
		end
		seen = rdata_o;
		while (busy_o !== 1'b0 && k < 800) begin
			wait_cyc(1);
			k++;
		end
		if (k >= 400) begin
			$display("Error handshake expected done seen timeout");
			n_fail++;
			give_verdict();
		end
	endtask

	// =========================================================================
	// Scenarios
	// =========================================================================
	task automatic t_startup;
		int k;
		k = 0;
		while (vco_tuning_o !== 1'b1 && k < 100) begin
			wait_cyc(1);
			k++;
		end
		check("settle cycles", 1, 32'(k >= 16 && k <= 20));
		if (k >= 100) give_verdict();
		check("cfg_reg0_o", 0, 32'(cfg_reg0_o));
		k = 0;
		while (ready_o !== 1'b1 && k < 3000) begin
			wait_cyc(1);
			k++;
		end
		check("vco_tuning_time", 1, 32'(k >= 2190 && k <= 2210));
		if (k >= 3000) give_verdict();
	endtask

	task automatic t_write;
		for (int i = 0; i < 3; i++) begin
			send({dat[i], 4'(i)});
			check("cfg_reg write", 32'(dat[i]), 32'(cfg[i]));
		end
		send({28'h000_0002, 4'hF});
		send({28'h7FF_FFFF, 4'h5});
		for (int i = 0; i < 3; i++) check("cfg_reg kept", 32'(dat[i]), 32'(cfg[i]));
		check("nvm_write_o count", 0, n_nvm);
	endtask

	task automatic t_read;
		for (int i = 0; i < 3; i++) begin
			send({24'h00_0000, 4'(i), 4'hE});
			check("rdata_o released", 32'hFFFF_FFFF, seen);
			send(32'h0000_0005);
			check("rdata_o", {dat[i], 4'(i)}, seen);
		end
		send(32'h0000_003E);
		send(32'h0000_0005);
		check("rdata_o unused address", 32'h0000_0000, seen);
	endtask

	task automatic t_copy;
		int nb;
		n_nvm = 0;
		n_busy = 0;
		send(32'h0000_001F);
		nb = n_busy;
		check("nvm_write_o count", 1, n_nvm);
		send(32'h0000_001F);
		check("nvm_write_o count", 2, n_nvm);
		n_busy = 0;
		send({~dat[0], 4'h0});
		check("busy_o copy wait", 20, nb - n_busy);
		for (int i = 1; i < 3; i++) send({~dat[i], 4'(i)});
		@(posedge ref_clk_i);
		pd_n_i <= 1'b0;
		wait_cyc(4);
		@(posedge ref_clk_i);
		pd_n_i <= 1'b1;
		wait_cyc(6);
		for (int i = 0; i < 3; i++) check("cfg_reg reload", i == 2 ? 0 : 32'(dat[i]), 32'(cfg[i]));
	endtask

	initial begin
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		t_startup();
		t_write();
		t_read();
		t_copy();
		give_verdict();
	end
endmodule
